//--- core/dcs_drive_ctrl.sv
// Purpose: decode the command word, sequence the drive, build the status word.
// Assumes: master and drive-side signals all on clk_sys; no synchronisers needed.
// Notes: command word is taken on cmd_word_wr; setpoint on setpoint_wr.
module dcs_drive_ctrl #(
    parameter int W = dcs_pkg::WORD_W,
    parameter logic [dcs_pkg::WORD_W-1:0] UP_STEP = dcs_pkg::RAMP_UP_STEP,
    parameter logic [dcs_pkg::WORD_W-1:0] DOWN_STEP = dcs_pkg::RAMP_DOWN_STEP,
    parameter logic [dcs_pkg::WORD_W-1:0] QUICK_STEP = dcs_pkg::QUICK_DOWN_STEP,
    parameter logic [dcs_pkg::WORD_W-1:0] POT_INC = dcs_pkg::POT_STEP
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmd_word_wr,
    input wire logic [dcs_pkg::WORD_W-1:0] cmd_word_wdata,
    output logic [dcs_pkg::WORD_W-1:0] drive_command_word,
    input wire logic setpoint_wr,
    input wire logic [dcs_pkg::WORD_W-1:0] setpoint_wdata,
    input wire logic use_pot_setpoint,
    input wire logic supply_ok,
    input wire logic init_done,
    input wire logic fault_event,
    input wire logic alarm_active,
    input wire logic master_ctrl_req,
    input wire logic motor_overtemp,
    input wire logic conv_overload,
    input wire logic [dcs_pkg::WORD_W-1:0] actual_speed,
    input wire logic [dcs_pkg::WORD_W-1:0] speed_tolerance,
    input wire logic [dcs_pkg::WORD_W-1:0] compare_speed,
    input wire logic [dcs_pkg::WORD_W-1:0] current_value,
    input wire logic [dcs_pkg::WORD_W-1:0] current_limit,
    output logic [dcs_pkg::WORD_W-1:0] drive_state_report_word,
    output logic [dcs_pkg::WORD_W-1:0] ramp_output,
    output logic [dcs_pkg::WORD_W-1:0] pot_setpoint,
    output logic pulse_enable
);
    import dcs_pkg::*;

    // elaboration check: the word layout needs exactly sixteen bits
    if (W != WORD_W) begin : g_bad_width
        $error("dcs_drive_ctrl supports only a 16-bit word");
    end

    // magnitude of a two's complement word, saturating at the top
    function automatic logic [WORD_W-1:0] mag(input logic [WORD_W-1:0] v);
        logic [WORD_W-1:0] r;
        r = v[WORD_W-1] ? (~v + 16'h0001) : v;
        if (r[WORD_W-1]) begin
            r = 16'h7FFF;
        end
        return r;
    endfunction : mag

    dcs_ramp_if #(.W(WORD_W)) rif ();

    logic [WORD_W-1:0] cmd_q, cmd_d;
    logic [WORD_W-1:0] sp_q, sp_d;
    logic [WORD_W-1:0] pot_q, pot_d;
    logic [WORD_W-1:0] stat_q, stat_d;
    logic on_prev_q, on_prev_d;
    logic ack_prev_q, ack_prev_d;
    logic fault_q, fault_d;
    logic cw_q, cw_d;
    logic pulse_q, pulse_d;
    dcs_state_type state_q, state_d;
    logic on_rise, ack_rise, on_cmd, coast_ok, quick_ok, op_en;
    logic signed [WORD_W-1:0] sp_base, sp_applied;
    logic [WORD_W:0] pot_sum;
    logic [WORD_W-1:0] dev;

    // command capture: only bit 10 moves while the master has no control
    always_comb begin
        cmd_d = cmd_q;
        if (cmd_word_wr) begin
            if (cmd_word_wdata[CMD_MASTER]) begin
                cmd_d = cmd_word_wdata & CMD_USED_MASK;
            end else begin
                cmd_d[CMD_MASTER] = 1'b0;
            end
        end
        sp_d = sp_q;
        if (setpoint_wr && cmd_q[CMD_MASTER]) begin
            sp_d = setpoint_wdata;
        end
    end

    assign on_cmd = cmd_q[CMD_ON];
    assign coast_ok = cmd_q[CMD_NO_COAST];
    assign quick_ok = cmd_q[CMD_NO_QUICK];
    assign op_en = cmd_q[CMD_OP_EN];
    assign on_rise = on_cmd & ~on_prev_q;
    assign ack_rise = cmd_q[CMD_FAULT_ACK] & ~ack_prev_q;

    // stored potentiometer setpoint, saturating signed
    always_comb begin
        pot_d = pot_q;
        pot_sum = '0;
        if (cmd_q[CMD_POT_UP] && !cmd_q[CMD_POT_DOWN]) begin
            pot_sum = {pot_q[WORD_W-1], pot_q} + {1'b0, POT_INC};
            pot_d = (pot_sum[WORD_W] != pot_sum[WORD_W-1]) ? 16'h7FFF
                : pot_sum[WORD_W-1:0];
        end else if (cmd_q[CMD_POT_DOWN] && !cmd_q[CMD_POT_UP]) begin
            pot_sum = {pot_q[WORD_W-1], pot_q} - {1'b0, POT_INC};
            pot_d = (pot_sum[WORD_W] != pot_sum[WORD_W-1]) ? 16'h8000
                : pot_sum[WORD_W-1:0];
        end
    end

    // fault latch: a new fault wins over an acknowledge in the same cycle
    always_comb begin
        fault_d = fault_q;
        if (ack_rise) begin
            fault_d = 1'b0;
        end
        if (fault_event) begin
            fault_d = 1'b1;
        end
        on_prev_d = on_cmd;
        ack_prev_d = cmd_q[CMD_FAULT_ACK];
    end

    // drive sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SW_INHIBIT: begin
                if (!on_cmd && coast_ok && quick_ok && supply_ok && init_done) begin
                    state_d = ST_SW_RDY_ON;
                end
            end
            ST_SW_RDY_ON: begin
                if (!coast_ok || !quick_ok) begin
                    state_d = ST_SW_INHIBIT;
                end else if (on_rise) begin
                    state_d = op_en ? ST_SW_RUN : ST_SW_READY;
                end
            end
            ST_SW_READY: begin
                if (!coast_ok || !quick_ok) begin
                    state_d = ST_SW_INHIBIT;
                end else if (!on_cmd) begin
                    state_d = ST_SW_RDY_ON;
                end else if (op_en) begin
                    state_d = ST_SW_RUN;
                end
            end
            ST_SW_RUN: begin
                if (!coast_ok) begin
                    state_d = ST_SW_INHIBIT;
                end else if (!quick_ok) begin
                    state_d = ST_SW_QUICK_STOP;
                end else if (!on_cmd) begin
                    state_d = ST_SW_RAMP_STOP;
                end else if (!op_en) begin
                    state_d = ST_SW_READY;
                end
            end
            ST_SW_RAMP_STOP: begin
                if (!coast_ok) begin
                    state_d = ST_SW_INHIBIT;
                end else if (!quick_ok) begin
                    state_d = ST_SW_QUICK_STOP;
                end else if (!op_en || rif.standstill) begin
                    state_d = ST_SW_RDY_ON;
                end
            end
            ST_SW_QUICK_STOP: begin
                if (!coast_ok || !op_en || rif.standstill) begin
                    state_d = ST_SW_INHIBIT;
                end
            end
            ST_SW_FAULT: begin
                if (!fault_q) begin
                    state_d = ST_SW_INHIBIT;
                end
            end
            default: begin
                state_d = ST_SW_INHIBIT;
            end
        endcase
        if (fault_q || fault_event) begin
            state_d = ST_SW_FAULT;
        end
    end

    // pulses: only in running or ramped stopping states with enable present
    always_comb begin
        pulse_d = op_en && (state_d == ST_SW_RUN || state_d == ST_SW_RAMP_STOP
            || state_d == ST_SW_QUICK_STOP);
    end

    // setpoint selection, reversal and ramp control
    always_comb begin
        sp_base = use_pot_setpoint ? signed'(pot_q) : signed'(sp_q);
        sp_applied = cmd_q[CMD_REVERSE] ? -sp_base : sp_base;
        rif.force_zero = !pulse_q || !cmd_q[CMD_RAMP_EN];
        rif.hold = (state_q == ST_SW_RUN) && !cmd_q[CMD_RAMP_RUN];
        rif.step_up = UP_STEP;
        rif.step_down = DOWN_STEP;
        rif.target = '0;
        if (state_q == ST_SW_RUN && cmd_q[CMD_SP_EN]) begin
            rif.target = sp_applied;
        end
        if (state_q == ST_SW_QUICK_STOP) begin
            rif.step_down = QUICK_STEP;
        end
    end

    dcs_ramp_gen #(.W(WORD_W)) u_ramp (
        .clk_sys(clk_sys),
        .rst(rst),
        .rif(rif)
    );

    // status word assembly
    always_comb begin
        dev = mag(rif.out_value - actual_speed);
        cw_d = cw_q;
        if (actual_speed != '0) begin
            cw_d = !actual_speed[WORD_W-1];
        end
        stat_d = '0;
        stat_d[ST_RDY_ON] = supply_ok && init_done && !pulse_q && !fault_q
            && (state_q == ST_SW_RDY_ON || state_q == ST_SW_READY);
        stat_d[ST_READY] = (state_q == ST_SW_READY) || (state_q == ST_SW_RUN);
        stat_d[ST_OP_EN] = (state_q == ST_SW_RUN) && op_en;
        stat_d[ST_FAULT] = fault_q;
        stat_d[ST_NO_COAST] = coast_ok;
        stat_d[ST_NO_QUICK] = quick_ok && (state_q != ST_SW_QUICK_STOP);
        stat_d[ST_INHIBIT] = (state_q == ST_SW_INHIBIT);
        stat_d[ST_ALARM] = alarm_active;
        stat_d[ST_DEV_OK] = (dev <= speed_tolerance);
        stat_d[ST_MASTER_REQ] = master_ctrl_req;
        stat_d[ST_SPEED_REACHED] = (mag(actual_speed) >= compare_speed);
        stat_d[ST_TORQUE_OK] = (mag(current_value) < current_limit);
        stat_d[ST_MOTOR_OT_N] = !motor_overtemp;
        stat_d[ST_CW] = cw_d;
        stat_d[ST_CONV_OL_N] = !conv_overload;
    end

    // registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_q <= CMD_RESET;
            sp_q <= SP_RESET;
            pot_q <= SP_RESET;
            stat_q <= STATUS_RESET;
            on_prev_q <= 1'b0;
            ack_prev_q <= 1'b0;
            fault_q <= 1'b0;
            cw_q <= 1'b0;
            pulse_q <= 1'b0;
            state_q <= ST_SW_INHIBIT;
        end else begin
            cmd_q <= cmd_d;
            sp_q <= sp_d;
            pot_q <= pot_d;
            stat_q <= stat_d;
            on_prev_q <= on_prev_d;
            ack_prev_q <= ack_prev_d;
            fault_q <= fault_d;
            cw_q <= cw_d;
            pulse_q <= pulse_d;
            state_q <= state_d;
        end
    end

    assign drive_command_word = cmd_q;
    assign drive_state_report_word = stat_q;
    assign ramp_output = rif.out_value;
    assign pot_setpoint = pot_q;
    assign pulse_enable = pulse_q;
endmodule : dcs_drive_ctrl

//--- core/dcs_pkg.sv
// Purpose: shared constants and types for the drive command/status word block.
// Assumes: one system clock, synchronous active-high reset.
// Notes: bit positions of both words are fixed; ramp steps are per clock.
// What this block does
// - command bit 0 low: ramp down with normal time, remove drive at standstill.
// - rising bit 0 enters ready; motor energised too if bit 3 high.
// - command bit 1 low: cut drive at once, coast; high permits switch on.
// - command bit 2 low: quick stop with quick ramp; high permits switch on.
// - command bit 3 low blocks pulses at once; high allows pulse enable.
// - bit 4 low zeroes ramp output; bit 5 low freezes it, high tracks.
// - command bit 6 low brakes with normal ramp; high accelerates to setpoint.
// - rising bit 7 clears fault; inhibit state follows if on still active.
// - bit 10 high gives master control; process data ignored while low.
// - command bit 11 high inverts the applied setpoint sign.
// - bit 13 raises stored potentiometer setpoint, bit 14 lowers it.
// - status bit 0: supply present, initialised, pulses locked.
// - status bit 1: on active and no fault; operation enable energises motor.
// - status bit 2: operation enabled, motor follows setpoint.
// - status bit 3: fault pending until acknowledged by command bit 7.
// - status bit 4: no coast stop; bit 5: no quick stop.
// - status bit 6: switch-on inhibited; left only with on low and bits 1 and 2 high.
// - status bit 7: alarm present, motor keeps running, no acknowledge.
// - status bits 8, 10, 11: deviation, speed and current comparisons.
// - status bit 9 requests the automation system to take control.
// - status bits 13 and 15 low flag motor and converter thermal alarms.
// - status bit 14 high for positive actual value, low for negative.
package dcs_pkg;
    localparam int WORD_W = 16;
    // command word bit positions
    localparam int CMD_ON = 0;
    localparam int CMD_NO_COAST = 1;
    localparam int CMD_NO_QUICK = 2;
    localparam int CMD_OP_EN = 3;
    localparam int CMD_RAMP_EN = 4;
    localparam int CMD_RAMP_RUN = 5;
    localparam int CMD_SP_EN = 6;
    localparam int CMD_FAULT_ACK = 7;
    localparam int CMD_MASTER = 10;
    localparam int CMD_REVERSE = 11;
    localparam int CMD_POT_UP = 13;
    localparam int CMD_POT_DOWN = 14;
    // only defined command bits are kept; reserved ones read back zero
    localparam logic [WORD_W-1:0] CMD_USED_MASK = 16'h6CFF;
    localparam logic [WORD_W-1:0] CMD_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] SP_RESET = 16'h0000;
    // status word bit positions
    localparam int ST_RDY_ON = 0;
    localparam int ST_READY = 1;
    localparam int ST_OP_EN = 2;
    localparam int ST_FAULT = 3;
    localparam int ST_NO_COAST = 4;
    localparam int ST_NO_QUICK = 5;
    localparam int ST_INHIBIT = 6;
    localparam int ST_ALARM = 7;
    localparam int ST_DEV_OK = 8;
    localparam int ST_MASTER_REQ = 9;
    localparam int ST_SPEED_REACHED = 10;
    localparam int ST_TORQUE_OK = 11;
    localparam int ST_RESERVED = 12;
    localparam int ST_MOTOR_OT_N = 13;
    localparam int ST_CW = 14;
    localparam int ST_CONV_OL_N = 15;
    localparam logic [WORD_W-1:0] STATUS_RESET = 16'hA000;
    // default ramp and potentiometer steps, in setpoint units per clock
    localparam logic [WORD_W-1:0] RAMP_UP_STEP = 16'h0001;
    localparam logic [WORD_W-1:0] RAMP_DOWN_STEP = 16'h0001;
    localparam logic [WORD_W-1:0] QUICK_DOWN_STEP = 16'h0004;
    localparam logic [WORD_W-1:0] POT_STEP = 16'h0001;
    // drive sequencing states
    typedef enum logic [6:0] {
        ST_SW_INHIBIT = 7'b000_0001,
        ST_SW_RDY_ON = 7'b000_0010,
        ST_SW_READY = 7'b000_0100,
        ST_SW_RUN = 7'b000_1000,
        ST_SW_RAMP_STOP = 7'b001_0000,
        ST_SW_QUICK_STOP = 7'b010_0000,
        ST_SW_FAULT = 7'b100_0000
    } dcs_state_type;
endpackage : dcs_pkg

//--- core/dcs_ramp_if.sv
// Purpose: carrier between the sequencer and the ramp generator.
// Assumes: both ends on clk_sys.
// Notes: target is already sign-corrected by the sequencer.
interface dcs_ramp_if #(parameter int W = 16);
    logic force_zero;
    logic hold;
    logic signed [W-1:0] target;
    logic [W-1:0] step_up;
    logic [W-1:0] step_down;
    logic signed [W-1:0] out_value;
    logic standstill;
    modport ctrl (output force_zero, hold, target, step_up, step_down,
        input out_value, standstill);
    modport ramp (input force_zero, hold, target, step_up, step_down,
        output out_value, standstill);
endinterface : dcs_ramp_if

//--- core/dcs_ramp_gen.sv
// Purpose: ramp generator moving its output toward a target by bounded steps.
// Assumes: steps are magnitudes; zero step freezes that direction.
// Notes: zero forcing wins over hold, hold wins over tracking.
module dcs_ramp_gen #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic rst,
    dcs_ramp_if.ramp rif
);
    import dcs_pkg::*;

    logic signed [W-1:0] out_q, out_d;
    logic signed [W:0] diff;
    logic signed [W:0] up_ext, dn_ext;

    // next output: zero, frozen or one step toward the target
    always_comb begin
        diff = {rif.target[W-1], rif.target} - {out_q[W-1], out_q};
        up_ext = signed'({1'b0, rif.step_up});
        dn_ext = signed'({1'b0, rif.step_down});
        out_d = out_q;
        if (rif.force_zero) begin
            out_d = '0;
        end else if (rif.hold) begin
            out_d = out_q;
        end else if (diff > up_ext && out_q >= 0) begin
            out_d = out_q + W'(up_ext);
        end else if (diff < -dn_ext && out_q <= 0) begin
            out_d = out_q - W'(dn_ext);
        end else if (diff > dn_ext) begin
            out_d = out_q + W'(dn_ext); // braking from negative side
        end else if (diff < -up_ext && out_q > 0) begin
            out_d = out_q - W'(dn_ext); // braking from positive side
        end else if (diff < -dn_ext) begin
            out_d = out_q - W'(dn_ext);
        end else begin
            out_d = rif.target;
        end
    end

    // output register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign rif.out_value = out_q;
    assign rif.standstill = (out_q == '0);
endmodule : dcs_ramp_gen

//--- verif/dcs_drive_properties.sv
// Purpose: port-level properties of the drive command/status block.
// Assumes: one clk_sys domain, rst synchronous active high.
// Notes: status word lags its causes by one registered stage.
module dcs_drive_properties
    import dcs_pkg::*;
#(
    parameter logic [WORD_W-1:0] POT_INC = POT_STEP
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmd_word_wr,
    input wire logic [dcs_pkg::WORD_W-1:0] cmd_word_wdata,
    input wire logic [dcs_pkg::WORD_W-1:0] drive_command_word,
    input wire logic fault_event,
    input wire logic alarm_active,
    input wire logic master_ctrl_req,
    input wire logic motor_overtemp,
    input wire logic conv_overload,
    input wire logic [dcs_pkg::WORD_W-1:0] actual_speed,
    input wire logic [dcs_pkg::WORD_W-1:0] drive_state_report_word,
    input wire logic [dcs_pkg::WORD_W-1:0] ramp_output,
    input wire logic [dcs_pkg::WORD_W-1:0] pot_setpoint,
    input wire logic pulse_enable
);
    logic [WORD_W-1:0] sw;
    logic [WORD_W-1:0] cw;
    // short aliases for the two words
    assign sw = drive_state_report_word;
    assign cw = drive_command_word;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    reserved_bits_a: assert property (!sw[ST_RESERVED] && (cw & ~CMD_USED_MASK) == 16'h0000)
        else $error("reserved bit set");
    thermal_flags_a: assert property (1'b1 |=> sw[ST_MOTOR_OT_N] == !$past(motor_overtemp)
        && sw[ST_CONV_OL_N] == !$past(conv_overload)) else $error("thermal flag wrong");
    mirror_flags_a: assert property (1'b1 |=> sw[ST_ALARM] == $past(alarm_active)
        && sw[ST_MASTER_REQ] == $past(master_ctrl_req)) else $error("alarm or request wrong");
    cmd_accept_a: assert property (cmd_word_wr && cmd_word_wdata[CMD_MASTER] |=>
        cw == ($past(cmd_word_wdata) & CMD_USED_MASK)) else $error("command not stored");
    cmd_refuse_a: assert property (cmd_word_wr && !cmd_word_wdata[CMD_MASTER] |=>
        cw == ($past(cw) & 16'hFBFF)) else $error("command taken without control");
    pulse_block_a: assert property (!cw[CMD_OP_EN] || !cw[CMD_NO_COAST] |=> !pulse_enable)
        else $error("pulses not blocked");
    ramp_zero_a: assert property (!cw[CMD_RAMP_EN] |-> ##[1:2] ramp_output == 16'h0000)
        else $error("ramp not zeroed");
    fault_flag_a: assert property (fault_event |-> ##[1:3] sw[ST_FAULT])
        else $error("fault flag missing");
    // status stage still shows its reset value one edge after release
    direction_flag_a: assert property (!rst && actual_speed != 16'h0000 |=>
        sw[ST_CW] == !$past(actual_speed[WORD_W-1])) else $error("direction flag wrong");
    pot_raise_a: assert property (cw[CMD_POT_UP] && !cw[CMD_POT_DOWN] && pot_setpoint != 16'h7FFF
        |=> pot_setpoint == $past(pot_setpoint) + POT_INC) else $error("pot not raised");
    // main scenarios reached
    cover property ($rose(pulse_enable));
    cover property (sw[ST_FAULT]);
    cover property (cw[CMD_POT_UP]);
endmodule : dcs_drive_properties

//--- verif/dcs_master_model.sv
// Purpose: fieldbus master issuing command and setpoint writes.
// Assumes: requests from the bench arrive one cycle ahead of the strobe.
// Notes: raw lets a write carry reserved bits on purpose.
module dcs_master_model
    import dcs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic send,
    input wire logic raw,
    input wire logic [dcs_pkg::WORD_W-1:0] word,
    input wire logic sp_send,
    input wire logic [dcs_pkg::WORD_W-1:0] sp_word,
    output logic cmd_word_wr,
    output logic [dcs_pkg::WORD_W-1:0] cmd_word_wdata,
    output logic setpoint_wr,
    output logic [dcs_pkg::WORD_W-1:0] setpoint_wdata
);
    // idle strobes and data at start
    initial begin
        cmd_word_wr = 1'b0;
        setpoint_wr = 1'b0;
        cmd_word_wdata = 16'h0000;
        setpoint_wdata = 16'h0000;
    end
    // one-cycle strobes; data lines toggle when not qualified
    always @(posedge clk_sys) begin
        cmd_word_wr <= send;
        setpoint_wr <= sp_send;
        cmd_word_wdata <= send ? (raw ? word : word & CMD_USED_MASK) : ~cmd_word_wdata;
        setpoint_wdata <= sp_send ? sp_word : ~setpoint_wdata;
    end
endmodule : dcs_master_model

//--- verif/tb_top.sv
// Purpose: self-checking bench for the drive command/status block.
// Assumes: supply and initialisation present throughout.
// Notes: random status inputs from a fixed seed.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcs_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic send = 1'b0, raw = 1'b0, sp_send = 1'b0, fault_event = 1'b0;
    logic alarm_active = 1'b0, master_ctrl_req = 1'b0, motor_overtemp = 1'b0;
    logic conv_overload = 1'b0, cmd_word_wr, setpoint_wr, pulse_enable;
    logic [WORD_W-1:0] word = 16'h0000, sp_word = 16'h0000, actual_speed = 16'h0001;
    logic [WORD_W-1:0] compare_speed = 16'h0000, current_value = 16'h0000;
    logic [WORD_W-1:0] current_limit = 16'h0000, cmd_word_wdata, setpoint_wdata;
    logic [WORD_W-1:0] speed_tolerance = 16'h0000;
    logic [WORD_W-1:0] drive_command_word, drive_state_report_word, ramp_output, pot_setpoint;
    logic [WORD_W-1:0] sp, r;
    integer seed = 16, num_errors = 0, total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    dcs_master_model master (.clk_sys(clk_sys), .send(send), .raw(raw), .word(word),
        .sp_send(sp_send), .sp_word(sp_word), .cmd_word_wr(cmd_word_wr),
        .cmd_word_wdata(cmd_word_wdata), .setpoint_wr(setpoint_wr),
        .setpoint_wdata(setpoint_wdata));
    dcs_drive_ctrl dut (.clk_sys(clk_sys), .rst(rst), .cmd_word_wr(cmd_word_wr),
        .cmd_word_wdata(cmd_word_wdata), .drive_command_word(drive_command_word),
        .setpoint_wr(setpoint_wr), .setpoint_wdata(setpoint_wdata), .use_pot_setpoint(1'b0),
        .supply_ok(1'b1), .init_done(1'b1), .fault_event(fault_event),
        .alarm_active(alarm_active), .master_ctrl_req(master_ctrl_req),
        .motor_overtemp(motor_overtemp), .conv_overload(conv_overload),
        .actual_speed(actual_speed), .speed_tolerance(speed_tolerance),
        .compare_speed(compare_speed),
        .current_value(current_value), .current_limit(current_limit),
        .drive_state_report_word(drive_state_report_word), .ramp_output(ramp_output),
        .pot_setpoint(pot_setpoint), .pulse_enable(pulse_enable));
    // expected status flags from inputs; ramp sits at zero, so deviation is the speed
    function automatic logic [WORD_W-1:0] exp_misc(input logic a, m, ot, ol);
        logic [WORD_W-1:0] spd;
        spd = actual_speed[WORD_W-1] ? 16'h0000 - actual_speed : actual_speed;
        exp_misc = 16'h0000;
        exp_misc[ST_ALARM] = a;
        exp_misc[ST_MASTER_REQ] = m;
        exp_misc[ST_MOTOR_OT_N] = !ot;
        exp_misc[ST_CONV_OL_N] = !ol;
        exp_misc[ST_DEV_OK] = spd <= speed_tolerance;
        exp_misc[ST_SPEED_REACHED] = spd >= compare_speed;
        exp_misc[ST_TORQUE_OK] = current_value < current_limit;
        exp_misc[ST_CW] = !actual_speed[WORD_W-1];
    endfunction : exp_misc
    task automatic chk(input string name, input logic [WORD_W-1:0] seen, exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic cmd(input logic [WORD_W-1:0] w, input logic bad);
        @(posedge clk_sys);
        send <= 1'b1;
        word <= w;
        raw <= bad;
        @(posedge clk_sys);
        send <= 1'b0;
        tick(6);
    endtask : cmd
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // hang guard
    initial begin
        #20000;
        num_errors = num_errors + 1;
        end_of_test();
    end
    // main sequence
    initial begin
        tick(7);
        chk("reset status", drive_state_report_word, 16'hA000);
        chk("reset pulses", pulse_enable, 1'b0);
        @(posedge clk_sys);
        rst <= 1'b0;
        cmd(16'h9706, 1'b1);
        chk("reserved ignored", drive_command_word, 16'h0406);
        chk("ready to switch on", drive_state_report_word & 16'h1077, 16'h0031);
        sp = 16'h0020 + ($random(seed) & 16'h001F);
        @(posedge clk_sys);
        sp_send <= 1'b1;
        sp_word <= sp;
        @(posedge clk_sys);
        sp_send <= 1'b0;
        cmd(16'h047F, 1'b0);
        chk("pulses on", pulse_enable, 1'b1);
        chk("run flags", drive_state_report_word & 16'h0047, 16'h0006);
        tick(80);
        chk("ramp tracks", ramp_output, sp);
        cmd(16'h0C5F, 1'b0);
        tick(20);
        chk("ramp frozen", ramp_output, sp);
        cmd(16'h0C7F, 1'b0);
        tick(150);
        chk("ramp reversed", ramp_output, 16'h0000 - sp);
        cmd(16'h0C7B, 1'b0);
        chk("quick flag", drive_state_report_word & 16'h0020, 16'h0000);
        r = ramp_output;
        tick(1);
        chk("quick step", ramp_output - r, QUICK_DOWN_STEP);
        tick(30);
        chk("inhibit after quick", drive_state_report_word & 16'h0041, 16'h0040);
        cmd(16'h0406, 1'b0);
        cmd(16'h047F, 1'b0);
        @(posedge clk_sys);
        fault_event <= 1'b1;
        @(posedge clk_sys);
        fault_event <= 1'b0;
        tick(4);
        chk("fault flag", drive_state_report_word & 16'h0008, 16'h0008);
        cmd(16'h04FF, 1'b0);
        tick(10);
        chk("fault cleared", drive_state_report_word & 16'h0048, 16'h0040);
        chk("inhibit holds", pulse_enable, 1'b0);
        cmd(16'h047E, 1'b0);
        cmd(16'h047F, 1'b0);
        tick(80);
        cmd(16'h047E, 1'b0);
        chk("ramped stop running", pulse_enable, 1'b1);
        tick(80);
        chk("ramped stop ramp", ramp_output, 16'h0000);
        chk("ramped stop pulses", pulse_enable, 1'b0);
        cmd(16'h2406, 1'b0);
        cmd(16'h6406, 1'b0);
        r = pot_setpoint;
        chk("pot raised", r > 16'h0000, 1'b1);
        tick(5);
        chk("pot both held", pot_setpoint, r);
        cmd(16'h4406, 1'b0);
        chk("pot lowered", pot_setpoint < r, 1'b1);
        cmd(16'h0000, 1'b0);
        chk("control dropped", drive_command_word, 16'h4006);
        repeat (24) begin
            @(posedge clk_sys);
            alarm_active <= $random(seed);
            master_ctrl_req <= $random(seed);
            motor_overtemp <= $random(seed);
            conv_overload <= $random(seed);
            actual_speed <= 16'h0001 | 16'($random(seed));
            speed_tolerance <= $random(seed) & 16'h7FFF;
            compare_speed <= $random(seed) & 16'h7FFF;
            current_value <= $random(seed) & 16'h7FFF;
            current_limit <= $random(seed) & 16'h7FFF;
            tick(2);
            chk("status flags", drive_state_report_word & 16'hEF80,
                exp_misc(alarm_active, master_ctrl_req, motor_overtemp, conv_overload));
        end
        end_of_test();
    end
endmodule : tb_top
bind dcs_drive_ctrl dcs_drive_properties #(.POT_INC(POT_INC)) u_props (.clk_sys(clk_sys),
    .rst(rst), .cmd_word_wr(cmd_word_wr), .cmd_word_wdata(cmd_word_wdata),
    .drive_command_word(drive_command_word), .fault_event(fault_event),
    .alarm_active(alarm_active), .master_ctrl_req(master_ctrl_req),
    .motor_overtemp(motor_overtemp), .conv_overload(conv_overload),
    .actual_speed(actual_speed), .drive_state_report_word(drive_state_report_word),
    .ramp_output(ramp_output), .pot_setpoint(pot_setpoint), .pulse_enable(pulse_enable));
